/* common/ssc_pkg.sv */
// Purpose: shared constants and types for the synchronous sram host controller
// Assumes: 256k x 18 flow-through sram, two byte lanes of nine bits
// Notes: pin levels are the electrical levels on the wires
package ssc_pkg;
    localparam int ADDR_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int DATA_W = LANE_W * LANES;
    // flow-through read: data valid one clock after the address edge
    localparam int READ_LAT = 1;
    // idle cycles with the clock running before the clock is parked
    localparam int STOP_IDLE = 2;
    localparam logic [1:0] LANES_NONE = 2'h3;
    localparam logic [1:0] LANES_ALL = 2'h0;
    // fixed tie level for the burst order select pin
    localparam logic ORDER_TIE = 1'h0;

    typedef struct packed {
        logic processor_address_strobe_n;
        logic controller_address_strobe_n;
        logic burst_step_request_n;
        logic select_one_low;
        logic select_two_high;
        logic select_three_low;
        logic global_write_strobe_n;
        logic byte_write_qualifier_n;
        logic [LANES-1:0] byte_lane_write_n;
        logic burst_order_select;
    } ssc_ctrl_t;

    typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_STOP} ssc_state_t;
endpackage

/* src/ssc_host.sv */
// Purpose: host controller that drives a synchronous sram in non-burst mode
// Assumes: one request per cycle; the sram clock is clk_sys gated by an enable from this block
// Notes: the sram clock is a registered enable, combined with clk_sys outside
// Notes on behaviour
// [RL1] a cycle is a write when the global strobe is low, or the qualifier and a lane strobe are low.
// [RL2] the memory is enabled only with select one low, two high, three low on an address strobe.
// [RL3] the memory keeps all state while its clock is stopped.
// [RL4] the clock restarts on a cycle that starts an access with an address strobe asserted.
// [RL5] the clock stops only after last write data is captured or last read data driven.
// [RL6] stopping after a read, after a write and while deselected are all supported.
// [RL7] the clock is parked low during a stop.
// [RL8] every control input is held inactive during a stop; the selects stay enabled (one low, two high, three low).
// [RL9] all address inputs are driven low during a stop.
// [RL10] write data lanes are held steady low during a stop, never floating.
// [RL11] the memory is used without bursts, one fresh address each cycle.
// [RL12] processor strobe high, controller strobe low, select one low, select two high, step fixed; the code drives the controller strobe low only on an access.
// [RL13] the burst order select is tied to a fixed level.
// [RL14] each strobed enabled edge loads the external address and starts one access.
`timescale 1ns/1ps
module ssc_host
    import ssc_pkg::*;
#(
    parameter int IDLE_STOP = STOP_IDLE
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // user request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [LANES-1:0] req_lanes,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic stopped,
    // sram pins
    output logic sram_clk_en,
    output ssc_ctrl_t sram_ctrl,
    output logic [ADDR_W-1:0] sram_addr,
    output logic [DATA_W-1:0] sram_dq_out,
    output logic sram_dq_oe,
    input wire logic [DATA_W-1:0] sram_dq_in
);
    ssc_state_t state;
    ssc_state_t next_state;
    logic [3:0] idle_cnt;
    logic rd_pend;
    logic wr_pend;
    logic [DATA_W-1:0] dq_s1;
    logic [DATA_W-1:0] dq_s2;
    logic rd_pend2;
    logic rd_pend3;
    logic rd_pend4;

    function automatic logic is_write(input logic gw_n, input logic bw_n,
                                      input logic [LANES-1:0] lane_n);
        is_write = !gw_n || (!bw_n && (lane_n != LANES_NONE)); // [RL1]
    endfunction

    wire logic take = req_valid;
    wire logic full_write = req_write && (req_lanes == {LANES{1'b1}});
    wire logic [LANES-1:0] lane_n = req_write ? ~req_lanes : LANES_NONE;
    wire logic gw_n = !full_write;
    wire logic bw_n = !(req_write && !full_write);
    // a read is still in flight until its data has come through the pin synchroniser
    wire logic drained = !rd_pend && !rd_pend2 && !rd_pend3 && !rd_pend4 && !wr_pend;
    wire logic idle_done = idle_cnt >= 4'(IDLE_STOP);

    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: if (!take && idle_done) next_state = ST_DRAIN;
            ST_DRAIN: begin
                if (take) next_state = ST_RUN; // [RL4]
                else if (drained) next_state = ST_STOP; // [RL5] [RL6]
            end
            ST_STOP: if (take) next_state = ST_RUN; // [RL4] [RL3]
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state <= ST_RUN;
            idle_cnt <= 4'h0;
        end else begin
            state <= next_state;
            idle_cnt <= take ? 4'h0 : (idle_done ? idle_cnt : idle_cnt + 4'h1);
        end
    end

    // control pins: deselected in reset, enabled after it, controller strobe low only on an access
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sram_clk_en <= 1'b0;
            sram_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, LANES_NONE, ORDER_TIE};
            sram_addr <= '0;
            sram_dq_out <= '0;
            sram_dq_oe <= 1'b0;
            req_ready <= 1'b0;
            stopped <= 1'b0;
        end else begin
            sram_clk_en <= (next_state != ST_STOP); // [RL7]
            sram_ctrl.processor_address_strobe_n <= 1'b1; // [RL12]
            sram_ctrl.burst_step_request_n <= 1'b1; // [RL12] [RL11]
            sram_ctrl.burst_order_select <= ORDER_TIE; // [RL13]
            sram_ctrl.select_one_low <= 1'b0; // [RL12] [RL2]
            sram_ctrl.select_two_high <= 1'b1; // [RL12] [RL2]
            sram_ctrl.select_three_low <= 1'b0; // [RL2]
            sram_ctrl.controller_address_strobe_n <= !take; // [RL14] [RL8]
            sram_ctrl.global_write_strobe_n <= take ? gw_n : 1'b1; // [RL1] [RL8]
            sram_ctrl.byte_write_qualifier_n <= take ? bw_n : 1'b1; // [RL1] [RL8]
            sram_ctrl.byte_lane_write_n <= take ? lane_n : LANES_NONE; // [RL8]
            sram_addr <= take ? req_addr : '0; // [RL9] [RL11]
            sram_dq_out <= (take && req_write) ? req_wdata : '0; // [RL10]
            sram_dq_oe <= !(take && !req_write); // [RL10]
            req_ready <= 1'b1;
            stopped <= (next_state == ST_STOP);
        end
    end

    // read return: pins synchronised over two flops, latency tracked alongside
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_pend <= 1'b0;
            rd_pend2 <= 1'b0;
            rd_pend3 <= 1'b0;
            rd_pend4 <= 1'b0;
            wr_pend <= 1'b0;
            dq_s1 <= '0;
            dq_s2 <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_pend <= take && !req_write;
            wr_pend <= take && is_write(gw_n, bw_n, lane_n);
            // pin cycle, memory edge, two sync flops: valid must line up with dq_s2
            rd_pend2 <= rd_pend;
            rd_pend3 <= rd_pend2;
            rd_pend4 <= rd_pend3;
            dq_s1 <= sram_dq_in;
            dq_s2 <= dq_s1;
            rd_valid <= rd_pend4; // [RL14]
            rd_data <= dq_s2;
        end
    end
endmodule

/* sim/ssc_host_properties.sv */
// Purpose: pin checks; Assumes: non-burst ties; Notes: sees top ports only
`timescale 1ns/1ps
module ssc_host_properties
    import ssc_pkg::*;
#(
    parameter int IDLE_STOP = STOP_IDLE
) (
    // watched ports
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [LANES-1:0] req_lanes,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic rd_valid,
    input wire logic stopped,
    input wire logic sram_clk_en,
    input wire ssc_ctrl_t sram_ctrl,
    input wire logic [ADDR_W-1:0] sram_addr,
    input wire logic [DATA_W-1:0] sram_dq_out,
    input wire logic sram_dq_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_access_loads: assert property (req_valid |=> !sram_ctrl.controller_address_strobe_n
        && sram_addr == $past(req_addr) && sram_clk_en) else $error("access not launched");
    a_read_quiet: assert property (req_valid && !req_write |=> !sram_dq_oe
        && sram_ctrl.global_write_strobe_n && sram_ctrl.byte_write_qualifier_n) else $error("read wrote");
    a_full_write: assert property (req_valid && req_write && req_lanes == 2'h3
        |=> !sram_ctrl.global_write_strobe_n) else $error("full write lost");
    a_read_answer: assert property (req_valid && !req_write |-> ##5 rd_valid)
        else $error("read data late");
    a_tie_pins: assert property (sram_ctrl.processor_address_strobe_n
        && sram_ctrl.burst_step_request_n && sram_ctrl.burst_order_select == ORDER_TIE)
        else $error("tie level moved");
    a_select_on: assert property (!sram_ctrl.controller_address_strobe_n |->
        !sram_ctrl.select_one_low && sram_ctrl.select_two_high && !sram_ctrl.select_three_low)
        else $error("chip not enabled");
    a_stop_quiet: assert property (stopped |-> !sram_clk_en && sram_addr == '0
        && sram_dq_out == '0 && sram_dq_oe && sram_ctrl.controller_address_strobe_n
        && sram_ctrl.global_write_strobe_n && sram_ctrl.byte_write_qualifier_n)
        else $error("stop noisy");
    a_busy_runs: assert property (req_valid |=> !stopped [*4])
        else $error("stopped mid access");
endmodule
bind ssc_host ssc_host_properties #(.IDLE_STOP(IDLE_STOP)) u_props (.*);

/* sim/ssc_sram_model.sv */
// Purpose: sram model; Assumes: non-burst pins; Notes: idle lanes toggle
`timescale 1ns/1ps
module ssc_sram_model
    import ssc_pkg::*;
(
    // pins
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire ssc_ctrl_t ctrl,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq,
    output logic [DATA_W-1:0] q
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    wire en = !ctrl.controller_address_strobe_n && !ctrl.select_one_low
        && ctrl.select_two_high && !ctrl.select_three_low;
    wire gw = !ctrl.global_write_strobe_n;
    wire wr = gw || (!ctrl.byte_write_qualifier_n && ctrl.byte_lane_write_n != LANES_NONE);
    initial q = '0;
    // array kept while clk_en is low, q still toggles on every clk_sys edge
    always @(posedge clk_sys) begin
        q <= ~q;
        if (clk_en && en) begin
            if (!mem.exists(addr)) mem[addr] = '0;
            for (int i = 0; i < LANES; i++)
                if (wr && (gw || !ctrl.byte_lane_write_n[i]))
                    mem[addr][i*LANE_W +: LANE_W] = dq[i*LANE_W +: LANE_W];
            if (!wr) q <= mem[addr];
        end
    end
endmodule

/* sim/testbench.sv */
// Purpose: bench; Assumes: 40 MHz clock; Notes: inputs move at falling edge
`timescale 1ns/1ps
module testbench;
    import ssc_pkg::*;
    logic clk_sys = 0, reset = 1, req_valid = 0, req_write = 0, rd_valid, sram_clk_en, stopped;
    logic [LANES-1:0] req_lanes = '0;
    logic [ADDR_W-1:0] req_addr = '0, sram_addr;
    logic [DATA_W-1:0] req_wdata = '0, rd_data, dq_out, dq_in;
    ssc_ctrl_t ctrl;
    int errors = 0, samples_checked = 0;
    ssc_host #(.IDLE_STOP(2)) u_ssc_host (.clk_sys, .reset, .req_valid, .req_write, .req_lanes,
        .req_addr, .req_wdata, .req_ready(), .rd_valid, .rd_data, .stopped, .sram_clk_en,
        .sram_ctrl(ctrl), .sram_addr, .sram_dq_out(dq_out), .sram_dq_oe(), .sram_dq_in(dq_in));
    ssc_sram_model u_ssc_sram_model (.clk_sys, .clk_en(sram_clk_en), .ctrl, .addr(sram_addr),
        .dq(dq_out), .q(dq_in));
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic chk(string what, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic access(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d, logic [1:0] l);
        @(negedge clk_sys);
        {req_valid, req_write, req_addr, req_wdata, req_lanes} = {1'b1, w, a, d, l};
        @(negedge clk_sys);
        req_valid = 0;
    endtask
    task automatic read_chk(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] exp);
        int n;
        access(0, a, '0, 2'h0);
        for (n = 0; n < 8 && rd_valid !== 1'b1; n++) @(negedge clk_sys);
        if (n == 8) begin
            errors++;
            $display("wrong value rd_valid expected 1 seen %b", rd_valid);
            wrap_up();
        end
        chk("rd_data", exp, rd_data);
    endtask
    task automatic t_write_read();
        access(1, 18'h00005, 18'h2a5c3, 2'h3);
        access(1, 18'h3ffff, 18'h15a3c, 2'h3);
        read_chk(18'h00005, 18'h2a5c3);
        read_chk(18'h3ffff, 18'h15a3c);
        $display("write read done");
    endtask
    task automatic t_byte_lane();
        access(1, 18'h00010, 18'h3ffff, 2'h3);
        access(1, 18'h00010, 18'h00000, 2'h1);
        access(1, 18'h00010, 18'h00000, 2'h0);
        read_chk(18'h00010, 18'h3fe00);
        $display("byte lane done");
    endtask
    task automatic t_stop_restart();
        repeat (8) @(negedge clk_sys);
        chk("stopped", 18'h1, {17'h0, stopped});
        chk("clk_en", 18'h0, {17'h0, sram_clk_en});
        chk("addr", 18'h0, sram_addr);
        chk("dq_out", 18'h0, dq_out);
        chk("strobe", 18'h1, {17'h0, ctrl.controller_address_strobe_n});
        read_chk(18'h00005, 18'h2a5c3);
        $display("stop restart done");
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        reset = 0;
        t_write_read();
        t_byte_lane();
        t_stop_restart();
        wrap_up();
    end
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
endmodule
